/* File: hw/tmo_map.svh */
`ifndef TMO_MAP_SVH
`define TMO_MAP_SVH
// array geometry
`define TMO_VAR_N 16
`define TMO_FSETS 4
`define TMO_FWAYS_FLD 0
`define TMO_FWAYS (`TMO_FWAYS_FLD + 2)
`define TMO_TOT (`TMO_VAR_N + `TMO_FWAYS * `TMO_FSETS)
`define TMO_HW_END (`TMO_VAR_N - 1 + (`TMO_FWAYS_FLD + 2) * `TMO_FSETS)
`define TMO_IW 5
// field widths
`define TMO_VPN_W 19
`define TMO_SPACE_ID_W 8
`define TMO_MSK_W 16
`define TMO_PFN_W 24
`define TMO_CDV_W 5
// config encodings
`define TMO_MT_JOINT 3'h1
`define TMO_MT_VARFIX 3'h4
`define TMO_IE_SW 2'h2
`define TMO_IE_HW 2'h3
`define TMO_REL_PROBE_MC 3'h3
// register field positions
`define TMO_HI_VPN 31:13
`define TMO_HI_INV 10
`define TMO_HI_SPACE_ID 7:0
`define TMO_LO_PFN 29:6
`define TMO_LO_CDV 5:1
`define TMO_LO_G 0
`define TMO_PM_MASK 28:13
`define TMO_IDX_P 31
// register words
`define TMO_HI_INV_WORD 32'h0000_0400
`define TMO_IDX_MISS 32'h8000_0000
`define TMO_ZERO_WORD 32'h0000_0000
// register selects for pipeline writes
`define TMO_SEL_HI 3'h0
`define TMO_SEL_LO0 3'h1
`define TMO_SEL_LO1 3'h2
`define TMO_SEL_PM 3'h3
`define TMO_SEL_IDX 3'h4
`endif

/* File: hw/tmo_pkg.sv */
`include "tmo_map.svh"
package tmo_pkg;
	typedef enum logic [2:0] {
		TMO_OP_NONE = 3'h0,
		TMO_OP_INV_SPACE = 3'h1,
		TMO_OP_INV_ALL = 3'h2,
		TMO_OP_PROBE = 3'h3,
		TMO_OP_READ = 3'h4,
		TMO_OP_WRITE = 3'h5
	} tmo_op_t;
	typedef logic [`TMO_TOT-1:0] tmo_vec_t;
	typedef logic [`TMO_IW-1:0] tmo_idx_t;
endpackage

/* File: hw/tmo_range.sv */
`timescale 1ns/10ps
`include "tmo_map.svh"
module tmo_range (
	input wire logic [2:0] mmu_type_field,
	input wire logic [1:0] invalidate_support_field,
	input wire tmo_pkg::tmo_idx_t ptr,
	output tmo_pkg::tmo_vec_t sel_vec
);
	import tmo_pkg::*;
	wire joint = mmu_type_field == `TMO_MT_JOINT;
	wire varfix = mmu_type_field == `TMO_MT_VARFIX;
	wire sw_walk = varfix && invalidate_support_field == `TMO_IE_SW;
	wire hw_walk = varfix && invalidate_support_field == `TMO_IE_HW;
	wire in_var = ptr <= `TMO_IW'(`TMO_VAR_N - 1);
	wire [`TMO_IW-1:0] f_off = ptr - `TMO_IW'(`TMO_VAR_N);
	wire [`TMO_IW-1:0] f_set = f_off / `TMO_IW'(`TMO_FWAYS);
	wire [`TMO_IW-1:0] set_lo = `TMO_IW'(`TMO_VAR_N) + f_set * `TMO_IW'(`TMO_FWAYS);
	wire [`TMO_IW-1:0] set_hi = set_lo + `TMO_IW'(`TMO_FWAYS - 1);
	genvar gv;
	for (gv = 0; gv < `TMO_TOT; gv++) begin : g_sel
		wire below_var = gv < `TMO_VAR_N;
		wire in_set = `TMO_IW'(gv) >= set_lo && `TMO_IW'(gv) <= set_hi;
		// joint array: whole array, pointer unused
		// hardware walk: both arrays as one, pointer unused
		// software walk: pointer picks variable array or one fixed set
		assign sel_vec[gv] = (joint && below_var) //R8
			|| (hw_walk && gv <= `TMO_HW_END) //R6
			|| (sw_walk && in_var && below_var) //R11
			|| (sw_walk && !in_var && in_set); //R9
	end
endmodule

/* File: hw/tmo_match.sv */
`timescale 1ns/10ps
`include "tmo_map.svh"
module tmo_match (
	input wire logic [`TMO_VPN_W-1:0] key_vpn,
	input wire logic [`TMO_SPACE_ID_W-1:0] key_space_id,
	input wire logic [`TMO_TOT-1:0][`TMO_VPN_W-1:0] vpn_a,
	input wire logic [`TMO_TOT-1:0][`TMO_MSK_W-1:0] mask_a,
	input wire logic [`TMO_TOT-1:0][`TMO_SPACE_ID_W-1:0] space_id_a,
	input wire tmo_pkg::tmo_vec_t g_vec,
	input wire tmo_pkg::tmo_vec_t inv_vec,
	output tmo_pkg::tmo_vec_t hit_vec
);
	import tmo_pkg::*;
	genvar gv;
	for (gv = 0; gv < `TMO_TOT; gv++) begin : g_hit
		wire [`TMO_VPN_W-1:0] keep = ~{{(`TMO_VPN_W - `TMO_MSK_W){1'b0}}, mask_a[gv]};
		wire vpn_eq = (vpn_a[gv] & keep) == (key_vpn & keep);
		wire id_ok = g_vec[gv] || space_id_a[gv] == key_space_id;
		// invalidated entries never match
		assign hit_vec[gv] = !inv_vec[gv] && vpn_eq && id_ok; //R13 R21
	end
endmodule

/* File: hw/tmo_tlb_maint.sv */
`timescale 1ns/10ps
`include "tmo_map.svh"
// Functional notes
// R1: hardware walk clears matches in both arrays
// R2: software walk needs variable then per-set ops
// R3: issuer keeps pointer below entry count
// R4: no cp0 access: unusable fault, no change
// R5: space invalidate hits same space, non-global
// R6: hardware walk spans both arrays as one
// R7: flush uses pointer and type, includes global
// R8: joint type flushes whole joint array
// R9: variable-fixed flush: variable array or one set
// R10: pinned entries are invalidated too
// R11: software walk pointer selects array or set
// R12: probe loads match index, miss sets msb
// R13: match on unmasked page and global or space
// R14: probe multi-match fault only newest release
// R15: read loads four registers from entry
// R16: invalid entry reads zeros plus invalidate bit
// R17: read returns single global in both lows
// R18: high word is page, five zeros, space
// R19: masked page and frame bits read zero
// R20: write fills entry, global is and
// R21: write with invalidate bit marks entry invalid
// R22: every operation completes in one update
module tmo_tlb_maint (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic cp0_usable,
	input wire logic [1:0] invalidate_support_field,
	input wire logic [2:0] mmu_type_field,
	input wire logic [2:0] arch_release,
	input wire logic op_valid,
	input wire tmo_pkg::tmo_op_t op_code,
	input wire logic cp0_wr,
	input wire logic [2:0] cp0_sel,
	input wire logic [31:0] cp0_wdata,
	input wire logic lk_valid,
	input wire logic [`TMO_VPN_W-1:0] lk_vpn,
	input wire logic [`TMO_SPACE_ID_W-1:0] lk_space_id,
	output logic [31:0] entry_high_reg,
	output logic [31:0] low_half_even_reg,
	output logic [31:0] low_half_odd_reg,
	output logic [31:0] size_mask_reg,
	output logic [31:0] slot_pointer_reg,
	output logic op_done,
	output logic cop_unusable,
	output logic machine_check,
	output logic lk_hit,
	output logic [`TMO_IW-1:0] lk_index
);
	import tmo_pkg::*;

	function automatic tmo_idx_t first_idx(input tmo_vec_t v);
		tmo_idx_t r;
		r = '0;
		for (int i = `TMO_TOT - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = `TMO_IW'(i);
			end
		end
		return r;
	endfunction

	function automatic logic many(input tmo_vec_t v);
		return (v & (v - 1'b1)) != '0;
	endfunction

	function automatic logic [`TMO_VPN_W-1:0] unmask_vpn(input logic [`TMO_VPN_W-1:0] v,
		input logic [`TMO_MSK_W-1:0] m);
		return v & ~{{(`TMO_VPN_W - `TMO_MSK_W){1'b0}}, m};
	endfunction

	function automatic logic [`TMO_PFN_W-1:0] unmask_pfn(input logic [`TMO_PFN_W-1:0] v,
		input logic [`TMO_MSK_W-1:0] m);
		return v & ~{{(`TMO_PFN_W - `TMO_MSK_W){1'b0}}, m};
	endfunction

	// entry storage
	logic [`TMO_TOT-1:0][`TMO_VPN_W-1:0] vpn_a;
	logic [`TMO_TOT-1:0][`TMO_MSK_W-1:0] mask_a;
	logic [`TMO_TOT-1:0][`TMO_SPACE_ID_W-1:0] space_id_a;
	logic [`TMO_TOT-1:0][`TMO_PFN_W-1:0] pfn0_a;
	logic [`TMO_TOT-1:0][`TMO_PFN_W-1:0] pfn1_a;
	logic [`TMO_TOT-1:0][`TMO_CDV_W-1:0] cdv0_a;
	logic [`TMO_TOT-1:0][`TMO_CDV_W-1:0] cdv1_a;
	tmo_vec_t g_vec;
	tmo_vec_t inv_r;
	tmo_vec_t inv_nxt;

	// architectural registers
	logic [31:0] hi_r, hi_nxt;
	logic [31:0] lo0_r, lo0_nxt;
	logic [31:0] lo1_r, lo1_nxt;
	logic [31:0] pm_r, pm_nxt;
	logic [31:0] idx_r, idx_nxt;
	logic done_r, cu_r, mc_r;
	logic lk_hit_r;
	tmo_idx_t lk_idx_r;

	// operation decode
	wire go = op_valid && cp0_usable;
	wire blocked = op_valid && !cp0_usable; //R4
	wire ie_on = invalidate_support_field == `TMO_IE_SW || invalidate_support_field == `TMO_IE_HW;
	// pointer taken as is: out-of-range values are the issuer's fault
	wire [`TMO_IW-1:0] ptr = idx_r[`TMO_IW-1:0]; //R3
	wire [`TMO_TOT-1:0] ptr_oh = `TMO_TOT'(1) << ptr;
	wire do_inv_sp = go && op_code == TMO_OP_INV_SPACE;
	wire do_inv_all = go && op_code == TMO_OP_INV_ALL;
	wire do_probe = go && op_code == TMO_OP_PROBE;
	wire do_read = go && op_code == TMO_OP_READ;
	wire do_write = go && op_code == TMO_OP_WRITE;

	// range and space selection
	tmo_vec_t sel_vec;
	tmo_vec_t space_id_eq;
	tmo_vec_t sp_cand;
	tmo_range u_range (
		.mmu_type_field(mmu_type_field),
		.invalidate_support_field(invalidate_support_field),
		.ptr(ptr),
		.sel_vec(sel_vec)
	);
	genvar gv;
	for (gv = 0; gv < `TMO_TOT; gv++) begin : g_space_id
		assign space_id_eq[gv] = space_id_a[gv] == hi_r[`TMO_HI_SPACE_ID];
	end
	// entries already invalid stay out of the candidate set
	assign sp_cand = space_id_eq & ~g_vec & ~inv_r; //R5
	// flush ignores space and global; pinned count plays no part
	wire [`TMO_TOT-1:0] inv_set = do_inv_sp ? (sel_vec & sp_cand) : //R1 R10
		do_inv_all ? sel_vec : '0; //R7 R10

	// probe against the high register
	tmo_vec_t pr_hit;
	tmo_match u_probe (
		.key_vpn(hi_r[`TMO_HI_VPN]),
		.key_space_id(hi_r[`TMO_HI_SPACE_ID]),
		.vpn_a(vpn_a),
		.mask_a(mask_a),
		.space_id_a(space_id_a),
		.g_vec(g_vec),
		.inv_vec(inv_r),
		.hit_vec(pr_hit)
	);
	wire pr_any = pr_hit != '0;
	wire pr_mc = do_probe && many(pr_hit) && arch_release >= `TMO_REL_PROBE_MC; //R14
	wire [31:0] pr_word = pr_any ? 32'(first_idx(pr_hit)) : `TMO_IDX_MISS; //R12

	// write: invalidate form or normal fill with duplicate check
	wire wr_inv = do_write && ie_on && hi_r[`TMO_HI_INV]; //R21
	wire wr_mc = do_write && !wr_inv && (pr_hit & ~ptr_oh) != '0; //R14
	wire wr_fill = do_write && !wr_inv && !wr_mc; //R20
	wire [`TMO_MSK_W-1:0] wr_mask = pm_r[`TMO_PM_MASK];

	// read assembly, masked bits returned as zero
	wire rd_inv = do_read && ie_on && inv_r[ptr]; //R16
	wire [`TMO_MSK_W-1:0] rm = mask_a[ptr];
	wire [31:0] rd_hi = {unmask_vpn(vpn_a[ptr], rm), 5'h00, space_id_a[ptr]}; //R18 R19
	wire [31:0] rd_lo0 = {2'h0, unmask_pfn(pfn0_a[ptr], rm), cdv0_a[ptr], g_vec[ptr]}; //R17
	wire [31:0] rd_lo1 = {2'h0, unmask_pfn(pfn1_a[ptr], rm), cdv1_a[ptr], g_vec[ptr]}; //R17
	wire [31:0] rd_pm = {3'h0, rm, 13'h0000};

	// lookup port shares the same entry state
	tmo_vec_t lk_vec;
	tmo_match u_lookup (
		.key_vpn(lk_vpn),
		.key_space_id(lk_space_id),
		.vpn_a(vpn_a),
		.mask_a(mask_a),
		.space_id_a(space_id_a),
		.g_vec(g_vec),
		.inv_vec(inv_r),
		.hit_vec(lk_vec)
	);

	wire wr_hi = cp0_wr && cp0_sel == `TMO_SEL_HI;
	wire wr_lo0 = cp0_wr && cp0_sel == `TMO_SEL_LO0;
	wire wr_lo1 = cp0_wr && cp0_sel == `TMO_SEL_LO1;
	wire wr_pm = cp0_wr && cp0_sel == `TMO_SEL_PM;
	wire wr_idx = cp0_wr && cp0_sel == `TMO_SEL_IDX;

	// a completing operation wins over a register write in the same cycle
	always_comb begin
		inv_nxt = inv_r | inv_set | (wr_inv ? ptr_oh : '0);
		if (wr_fill) begin
			inv_nxt = inv_nxt & ~ptr_oh;
		end
		hi_nxt = wr_hi ? cp0_wdata : hi_r;
		lo0_nxt = wr_lo0 ? cp0_wdata : lo0_r;
		lo1_nxt = wr_lo1 ? cp0_wdata : lo1_r;
		pm_nxt = wr_pm ? cp0_wdata : pm_r;
		idx_nxt = wr_idx ? cp0_wdata : idx_r;
		if (rd_inv) begin
			hi_nxt = `TMO_HI_INV_WORD; //R16
			lo0_nxt = `TMO_ZERO_WORD;
			lo1_nxt = `TMO_ZERO_WORD;
			pm_nxt = `TMO_ZERO_WORD;
		end else if (do_read) begin
			hi_nxt = rd_hi; //R15
			lo0_nxt = rd_lo0;
			lo1_nxt = rd_lo1;
			pm_nxt = rd_pm;
		end
		if (do_probe && !pr_mc) begin
			idx_nxt = pr_word; //R12
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			inv_r <= '1;
			hi_r <= `TMO_ZERO_WORD;
			lo0_r <= `TMO_ZERO_WORD;
			lo1_r <= `TMO_ZERO_WORD;
			pm_r <= `TMO_ZERO_WORD;
			idx_r <= `TMO_ZERO_WORD;
		end else begin
			inv_r <= inv_nxt; //R22
			hi_r <= hi_nxt;
			lo0_r <= lo0_nxt;
			lo1_r <= lo1_nxt;
			pm_r <= pm_nxt;
			idx_r <= idx_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			done_r <= 1'b0;
			cu_r <= 1'b0;
			mc_r <= 1'b0;
			lk_hit_r <= 1'b0;
			lk_idx_r <= '0;
		end else begin
			done_r <= op_valid;
			cu_r <= blocked; //R4
			mc_r <= pr_mc || wr_mc; //R14
			lk_hit_r <= lk_valid && lk_vec != '0; //R21
			lk_idx_r <= first_idx(lk_vec);
		end
	end

	// entry contents; the single global bit is the and of both lows
	always_ff @(posedge mclk) begin
		if (wr_fill) begin
			vpn_a[ptr] <= unmask_vpn(hi_r[`TMO_HI_VPN], wr_mask); //R19 R20
			space_id_a[ptr] <= hi_r[`TMO_HI_SPACE_ID];
			mask_a[ptr] <= wr_mask;
			pfn0_a[ptr] <= unmask_pfn(lo0_r[`TMO_LO_PFN], wr_mask);
			pfn1_a[ptr] <= unmask_pfn(lo1_r[`TMO_LO_PFN], wr_mask);
			cdv0_a[ptr] <= lo0_r[`TMO_LO_CDV];
			cdv1_a[ptr] <= lo1_r[`TMO_LO_CDV];
			g_vec[ptr] <= lo0_r[`TMO_LO_G] & lo1_r[`TMO_LO_G]; //R20
		end
	end

	assign entry_high_reg = hi_r;
	assign low_half_even_reg = lo0_r;
	assign low_half_odd_reg = lo1_r;
	assign size_mask_reg = pm_r;
	assign slot_pointer_reg = idx_r;
	assign op_done = done_r;
	assign cop_unusable = cu_r;
	assign machine_check = mc_r;
	assign lk_hit = lk_hit_r;
	assign lk_index = lk_idx_r;

	a_cu_blocks_op: assert property ( //R4
		@(posedge mclk) disable iff (sys_rst)
		blocked |=> cu_r && !mc_r && $stable(inv_r) && ($stable(idx_r) && $stable(hi_r) || $past(cp0_wr)))
		else $error("operation without cp0 access changed state");

	a_space_keeps_global: assert property ( //R5
		@(posedge mclk) disable iff (sys_rst)
		do_inv_sp |=> ((inv_r ^ $past(inv_r)) & ($past(g_vec) | ~$past(space_id_eq))) == '0)
		else $error("space invalidate touched a global or foreign entry");

	a_hw_walk_all: assert property ( //R1
		@(posedge mclk) disable iff (sys_rst)
		do_inv_sp && mmu_type_field == `TMO_MT_VARFIX && invalidate_support_field == `TMO_IE_HW
		|=> (inv_r & $past(sp_cand)) == $past(sp_cand))
		else $error("hardware walk missed a matching entry");

	a_joint_flush: assert property ( //R8
		@(posedge mclk) disable iff (sys_rst)
		do_inv_all && mmu_type_field == `TMO_MT_JOINT |=> &inv_r[`TMO_VAR_N-1:0])
		else $error("joint flush left an entry valid");

	a_var_flush: assert property ( //R9
		@(posedge mclk) disable iff (sys_rst)
		do_inv_all && mmu_type_field == `TMO_MT_VARFIX && invalidate_support_field == `TMO_IE_SW
		&& ptr < `TMO_IW'(`TMO_VAR_N) |=> &inv_r[`TMO_VAR_N-1:0] && inv_r[`TMO_TOT-1:`TMO_VAR_N]
		== $past(inv_r[`TMO_TOT-1:`TMO_VAR_N]))
		else $error("variable flush range wrong");

	a_probe_miss_msb: assert property ( //R12
		@(posedge mclk) disable iff (sys_rst)
		do_probe && !pr_any |=> idx_r[`TMO_IDX_P] ##1 idx_r[`TMO_IDX_P] || $past(cp0_wr))
		else $error("probe miss did not set pointer msb");

	a_probe_hit_idx: assert property ( //R12
		@(posedge mclk) disable iff (sys_rst)
		do_probe && pr_any && !many(pr_hit) |=> idx_r == 32'(first_idx($past(pr_hit))))
		else $error("probe hit loaded wrong index");

	a_probe_mc_release: assert property ( //R14
		@(posedge mclk) disable iff (sys_rst)
		do_probe && arch_release < `TMO_REL_PROBE_MC && !wr_mc |=> !mc_r)
		else $error("probe fault raised on older release");

	a_read_inv_zero: assert property ( //R16
		@(posedge mclk) disable iff (sys_rst)
		rd_inv |=> hi_r == `TMO_HI_INV_WORD && lo0_r == '0 && lo1_r == '0 && pm_r == '0)
		else $error("invalid entry read not zeroed");

	a_read_global_pair: assert property ( //R17
		@(posedge mclk) disable iff (sys_rst)
		do_read && !rd_inv |=> lo0_r[`TMO_LO_G] == lo1_r[`TMO_LO_G] && hi_r[12:8] == 5'h00)
		else $error("read global or high gap wrong");

	a_write_inv_mark: assert property ( //R21
		@(posedge mclk) disable iff (sys_rst)
		wr_inv |=> inv_r[$past(ptr)] && !mc_r)
		else $error("invalidating write did not mark entry");

	a_write_fill_valid: assert property ( //R20
		@(posedge mclk) disable iff (sys_rst)
		wr_fill |=> !inv_r[$past(ptr)] && g_vec[$past(ptr)] == ($past(lo0_r[0]) & $past(lo1_r[0])))
		else $error("write fill wrong");

	a_done_one_cycle: assert property ( //R22
		@(posedge mclk) disable iff (sys_rst)
		op_valid |=> done_r ##1 !done_r || $past(op_valid))
		else $error("operation did not complete in one cycle");
endmodule

/* File: verification/tmo_pipe_model.sv */
`timescale 1ns/10ps
`include "tmo_map.svh"
module tmo_pipe_model (
	input wire logic mclk,
	input wire logic op_done,
	input wire logic cop_unusable,
	input wire logic machine_check,
	input wire logic lk_hit,
	input wire logic [`TMO_IW-1:0] lk_index,
	output tmo_pkg::tmo_op_t op_code,
	output logic op_valid,
	output logic cp0_wr,
	output logic [2:0] cp0_sel,
	output logic [31:0] cp0_wdata,
	output logic lk_valid,
	output logic [`TMO_VPN_W-1:0] lk_vpn,
	output logic [`TMO_SPACE_ID_W-1:0] lk_space_id
);
	import tmo_pkg::*;
	initial begin
		op_code = TMO_OP_NONE;
		op_valid = 1'b0;
		cp0_wr = 1'b0;
		cp0_sel = 3'h7;
		cp0_wdata = 32'h0;
		lk_valid = 1'b0;
		lk_vpn = '0;
		lk_space_id = '0;
	end
	// callers keep the pointer below the entry count
	task automatic wr_reg(input logic [2:0] sel, input logic [31:0] val);
		@(posedge mclk);
		#1;
		cp0_wr = 1'b1;
		cp0_sel = sel;
		cp0_wdata = val;
		@(posedge mclk);
		#1;
		cp0_wr = 1'b0;
		cp0_wdata = ~val;
	endtask
	// one op pulse, results sampled 1ns after the taking edge
	task automatic issue(input tmo_op_t k, output logic d, output logic c, output logic m);
		@(posedge mclk);
		#1;
		op_valid = 1'b1;
		op_code = k;
		@(posedge mclk);
		#1;
		op_valid = 1'b0;
		op_code = TMO_OP_NONE;
		d = op_done;
		c = cop_unusable;
		m = machine_check;
	endtask
	task automatic lookup(input logic [31:0] h, output logic hit, output logic [`TMO_IW-1:0] idx);
		@(posedge mclk);
		#1;
		lk_valid = 1'b1;
		lk_vpn = h[`TMO_HI_VPN];
		lk_space_id = h[`TMO_HI_SPACE_ID];
		@(posedge mclk);
		#1;
		lk_valid = 1'b0;
		lk_vpn = ~lk_vpn;
		hit = lk_hit;
		idx = lk_index;
	endtask
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
`include "tmo_map.svh"
module tb_top;
	import tmo_pkg::*;
	logic mclk, sys_rst, cp0_usable, op_valid, cp0_wr, lk_valid, op_done, cu, mc, lk_hit, d, c, m;
	logic [1:0] ie;
	logic [2:0] mt, rel, cp0_sel;
	logic [31:0] cp0_wdata, hi, lo0, lo1, pm, ptr;
	logic [`TMO_VPN_W-1:0] lk_vpn;
	logic [`TMO_SPACE_ID_W-1:0] lk_space_id;
	logic [`TMO_IW-1:0] lk_index, li;
	tmo_op_t op_code;
	int errors, n_compared;
	tmo_tlb_maint i_tmo_tlb_maint (.mclk(mclk), .sys_rst(sys_rst), .cp0_usable(cp0_usable),
		.invalidate_support_field(ie), .mmu_type_field(mt), .arch_release(rel), .op_valid(op_valid),
		.op_code(op_code), .cp0_wr(cp0_wr), .cp0_sel(cp0_sel), .cp0_wdata(cp0_wdata), .lk_valid(lk_valid),
		.lk_vpn(lk_vpn), .lk_space_id(lk_space_id), .entry_high_reg(hi), .low_half_even_reg(lo0),
		.low_half_odd_reg(lo1), .size_mask_reg(pm), .slot_pointer_reg(ptr), .op_done(op_done),
		.cop_unusable(cu), .machine_check(mc), .lk_hit(lk_hit), .lk_index(lk_index));
	tmo_pipe_model i_tmo_pipe_model (.mclk(mclk), .op_done(op_done), .cop_unusable(cu),
		.machine_check(mc), .lk_hit(lk_hit), .lk_index(lk_index), .op_code(op_code), .op_valid(op_valid),
		.cp0_wr(cp0_wr), .cp0_sel(cp0_sel), .cp0_wdata(cp0_wdata), .lk_valid(lk_valid), .lk_vpn(lk_vpn),
		.lk_space_id(lk_space_id));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [2:0] s, input logic [31:0] v);
		i_tmo_pipe_model.wr_reg(s, v);
	endtask
	task automatic op(input tmo_op_t k, input logic em);
		i_tmo_pipe_model.issue(k, d, c, m);
		chk1("op_done", 1'b1, d);
		chk1("cop_unusable", ~cp0_usable, c);
		chk1("machine_check", em, m);
	endtask
	task automatic rd(input logic [4:0] i, input logic [31:0] eh);
		wr(`TMO_SEL_IDX, {27'h0, i});
		op(TMO_OP_READ, 1'b0);
		chk32("entry_high", eh, hi);
	endtask
	task automatic ent(input logic [4:0] i, input logic [31:0] h, input logic [31:0] l, input logic em);
		wr(`TMO_SEL_HI, h);
		wr(`TMO_SEL_LO0, l);
		wr(`TMO_SEL_LO1, l);
		wr(`TMO_SEL_PM, 32'h0);
		wr(`TMO_SEL_IDX, {27'h0, i});
		op(TMO_OP_WRITE, em);
	endtask
	initial begin
		errors = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		cp0_usable = 1'b1;
		ie = `TMO_IE_HW;
		mt = `TMO_MT_VARFIX;
		rel = 3'h3;
		repeat (8) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		chk32("slot_pointer", 32'h0, ptr);
		rd(5'h0, `TMO_HI_INV_WORD);
		chk32("low_even", 32'h0, lo0);
		chk32("size_mask", 32'h0, pm);
		$display("reset test done");
		wr(`TMO_SEL_HI, 32'hABCD_E021);
		wr(`TMO_SEL_LO0, 32'hC123_45C7);
		wr(`TMO_SEL_LO1, 32'h0ABC_DEF2);
		wr(`TMO_SEL_PM, 32'h0000_6000);
		wr(`TMO_SEL_IDX, 32'h3);
		op(TMO_OP_WRITE, 1'b0);
		rd(5'h3, 32'hABCD_8021);
		chk32("low_even", 32'h0123_4506, lo0);
		chk32("low_odd", 32'h0ABC_DE32, lo1);
		chk32("size_mask", 32'h0000_6000, pm);
		$display("write read test done");
		wr(`TMO_SEL_HI, 32'hABCD_E021);
		op(TMO_OP_PROBE, 1'b0);
		chk32("slot_pointer", 32'h3, ptr);
		wr(`TMO_SEL_HI, 32'hABCD_8022);
		op(TMO_OP_PROBE, 1'b0);
		chk32("slot_pointer", `TMO_IDX_MISS, ptr);
		i_tmo_pipe_model.lookup(32'hABCD_8021, d, li);
		chk1("lk_hit", 1'b1, d);
		chk32("lk_index", 32'h3, {27'h0, li});
		$display("probe test done");
		wr(`TMO_SEL_IDX, 32'h3);
		cp0_usable = 1'b0;
		op(TMO_OP_INV_ALL, 1'b0);
		op(TMO_OP_PROBE, 1'b0);
		chk32("slot_pointer", 32'h3, ptr);
		cp0_usable = 1'b1;
		rd(5'h3, 32'hABCD_8021);
		$display("unusable test done");
		wr(`TMO_SEL_HI, 32'hABCD_8421);
		op(TMO_OP_WRITE, 1'b0);
		i_tmo_pipe_model.lookup(32'hABCD_8021, d, li);
		chk1("lk_hit", 1'b0, d);
		rd(5'h3, `TMO_HI_INV_WORD);
		$display("write invalidate test done");
		ent(5'h5, 32'h3000_0021, 32'h0, 1'b0);
		ent(5'h15, 32'h2000_0021, 32'h1, 1'b0);
		ent(5'h16, 32'h7000_0033, 32'h0, 1'b0);
		ent(5'h17, 32'h5000_0021, 32'h0, 1'b0);
		wr(`TMO_SEL_HI, 32'h0000_0021);
		wr(`TMO_SEL_IDX, 32'h5);
		op(TMO_OP_INV_SPACE, 1'b0);
		rd(5'h5, `TMO_HI_INV_WORD);
		rd(5'h17, `TMO_HI_INV_WORD);
		rd(5'h15, 32'h2000_0021);
		rd(5'h16, 32'h7000_0033);
		$display("space invalidate test done");
		ie = `TMO_IE_SW;
		ent(5'h2, 32'h6000_0044, 32'h1, 1'b0);
		wr(`TMO_SEL_IDX, 32'h14);
		op(TMO_OP_INV_ALL, 1'b0);
		rd(5'h15, `TMO_HI_INV_WORD);
		rd(5'h2, 32'h6000_0044);
		wr(`TMO_SEL_IDX, 32'h7);
		op(TMO_OP_INV_ALL, 1'b0);
		rd(5'h2, `TMO_HI_INV_WORD);
		rd(5'h16, 32'h7000_0033);
		mt = `TMO_MT_JOINT;
		ent(5'h1, 32'h1000_0055, 32'h1, 1'b0);
		op(TMO_OP_INV_ALL, 1'b0);
		rd(5'h1, `TMO_HI_INV_WORD);
		$display("flush test done");
		ie = `TMO_IE_HW;
		mt = `TMO_MT_VARFIX;
		ent(5'h4, 32'h4000_0011, 32'h0, 1'b0);
		ent(5'h6, 32'h4000_0012, 32'h1, 1'b0);
		wr(`TMO_SEL_HI, 32'h4000_0011);
		rel = 3'h2;
		op(TMO_OP_PROBE, 1'b0);
		chk32("slot_pointer", 32'h4, ptr);
		wr(`TMO_SEL_IDX, 32'h9);
		rel = 3'h3;
		op(TMO_OP_PROBE, 1'b1);
		chk32("slot_pointer", 32'h9, ptr);
		ent(5'h7, 32'h4000_0011, 32'h0, 1'b1);
		rd(5'h7, `TMO_HI_INV_WORD);
		ie = 2'h0;
		op(TMO_OP_INV_ALL, 1'b0);
		ie = `TMO_IE_HW;
		rd(5'h4, 32'h4000_0011);
		$display("multi match test done");
		report_and_stop;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		report_and_stop;
	end
endmodule
